// >>> hw/lan_frame_fifo.sv
/*
  Transmit and receive frame FIFOs with the byte/serial/nibble
  converters of the MAC. The host side streams bytes on i_core_clk;
  the PHY clocks are plain pins sampled by i_core_clk, so they must be
  well below half its rate (bench: 5 MHz against 40 MHz).
*/
// Overview of operation
// - Separate one-way transmit and receive FIFOs
// - Several queued frames leave after minimum gap
// - Transmit starts once threshold bytes are stored
// - Collision or underrun resends from FIFO copy
// - Runt received frames dropped inside FIFO
// - Host side streams every cycle, link-independent
// - Deep buffers ride out host stalls; receive overflow drops frame
// - Bytes leave as serial bits or nibbles
// - Serial bits or nibbles assembled into bytes
// - Full duplex runs both paths at once
// - Receive lines ignored while data-valid (MII) or carrier sense (serial) low
`default_nettype none
`include "lan_fifo_consts.svh"

module lan_frame_fifo
  import lan_fifo_pkg::*;
#(
  parameter int TX_DEPTH = `LF_TX_DEPTH,
  parameter int RX_DEPTH = `LF_RX_DEPTH
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_mii_mode,
  input  wire logic                          i_full_duplex,
  input  wire logic                          i_runt_drop,
  input  wire logic [$clog2(TX_DEPTH):0]     i_tx_threshold,
  input  wire fifo_word_s                    i_tx_word,
  input  wire logic                          i_tx_valid,
  output var  logic                          o_tx_ready,
  output var  fifo_word_s                    o_rx_word,
  output var  logic                          o_rx_valid,
  input  wire logic                          i_rx_ready,
  input  wire logic                          i_tx_clk,
  output var  logic [3:0]                    o_txd,
  output var  logic                          o_tx_en,
  input  wire logic                          i_col,
  input  wire logic                          i_rx_clk,
  input  wire logic [3:0]                    i_rxd,
  input  wire logic                          i_rx_dv,
  input  wire logic                          i_crs,
  output var  logic                          o_tx_done,
  output var  logic                          o_tx_collision,
  output var  logic                          o_tx_underrun,
  output var  logic                          o_rx_frame,
  output var  logic                          o_rx_runt,
  output var  logic                          o_rx_overflow
);

  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Link units per byte: two nibbles or eight bits
  function automatic logic [3:0] units_per_byte(input logic mii);
    return mii ? `LF_UNITS_MII : `LF_UNITS_SER;
  endfunction : units_per_byte

  // First unit of a byte on the transmit lines, low bits first
  function automatic logic [3:0] unit_of(input logic [7:0] b,
                                         input logic mii);
    return mii ? b[3:0] : {3'h0, b[0]};
  endfunction : unit_of

  // The byte with its first unit shifted away
  function automatic logic [7:0] rest_of(input logic [7:0] b,
                                         input logic mii);
    return mii ? {4'h0, b[7:4]} : {1'b0, b[7:1]};
  endfunction : rest_of

  // ------------------------------------------------------------
  // Pin synchronisers and link clock edge detection
  // ------------------------------------------------------------
  logic [1:0] tclk_s1_r, tclk_s2_r;   // Rx, Tx clocks: stage 1, 2
  logic       tclk_s3_r;              // Tx clock delayed for edge
  logic       rclk_s3_r;              // Rx clock delayed for edge
  logic [6:0] pin_s1_r, pin_s2_r;     // col, dv, crs, rxd[3:0]

  // Two flops per pin; stage 1 feeds stage 2 only
  always_ff @(posedge i_core_clk) begin
    tclk_s1_r <= {i_rx_clk, i_tx_clk};
    tclk_s2_r <= tclk_s1_r;
    pin_s1_r  <= {i_col, i_rx_dv, i_crs, i_rxd};
    pin_s2_r  <= pin_s1_r;
    tclk_s3_r <= tclk_s2_r[0];
    rclk_s3_r <= tclk_s2_r[1];
  end

  wire       tx_tick = tclk_s2_r[0] & ~tclk_s3_r;
  wire       rx_tick = tclk_s2_r[1] & ~rclk_s3_r;
  wire       col_s   = pin_s2_r[6];
  wire       dv_s    = pin_s2_r[5];
  wire       crs_s   = pin_s2_r[4];
  wire [3:0] rxd_s   = pin_s2_r[3:0];

  // ------------------------------------------------------------
  // Transmit FIFO, host side
  // ------------------------------------------------------------
  fifo_word_s     tx_mem_r [TX_DEPTH];   // Transmit storage
  logic [TAW:0]   tx_wr_r;               // Host write pointer
  logic [TAW:0]   tx_rd_r;               // Link read pointer
  logic [TAW:0]   tx_fs_r;               // Start of unsent frame
  logic [TAW:0]   tx_frames_r;           // Complete frames queued
  logic           tx_done_w;             // Frame went out whole

  wire [TAW:0] tx_used  = tx_wr_r - tx_fs_r;
  wire [TAW:0] tx_ahead = tx_wr_r - tx_rd_r;
  wire         tx_push  = i_tx_valid & o_tx_ready;
  wire         tx_fin   = tx_push & i_tx_word.last;
  wire         tx_room  = tx_used < (TAW+1)'(TX_DEPTH - 1);

  // Bytes of a frame in flight stay held until it is sent, so a
  // retry never needs the host again; a frame larger than the
  // FIFO therefore cannot be retried.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tx_wr_r    <= '0;
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= tx_room;
      if (tx_push) begin
        tx_mem_r[tx_wr_r[TAW-1:0]] <= i_tx_word;
        tx_wr_r <= tx_wr_r + 1'b1;
      end
    end
  end

  // Count of whole frames waiting, for back-to-back sends
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tx_frames_r <= '0;
    end else if (tx_fin && !tx_done_w) begin
      tx_frames_r <= tx_frames_r + 1'b1;
    end else if (!tx_fin && tx_done_w) begin
      tx_frames_r <= tx_frames_r - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Transmit sequencer and serialiser
  // ------------------------------------------------------------
  tx_state_e   tx_state_r;   // Sequencer state
  logic [7:0]  tx_sh_r;      // Units of current byte still to go
  logic [3:0]  tx_cnt_r;     // Units left in the shift register
  logic        tx_last_r;    // Current byte ends the frame
  logic        tx_whole_r;   // After underrun wait for whole frame
  logic [6:0]  tx_gap_r;     // Gap ticks counted

  wire fifo_word_s tx_head = tx_mem_r[tx_rd_r[TAW-1:0]];
  wire        tx_avail  = tx_ahead != '0;
  wire        tx_thr_ok = !tx_whole_r && tx_used != '0 &&
                          tx_used >= i_tx_threshold;
  wire        tx_start  = tx_frames_r != '0 || tx_thr_ok;
  wire        col_hit   = col_s & ~i_full_duplex;
  wire        tx_end    = tx_tick && tx_cnt_r == '0 && tx_last_r;
  wire        tx_starve = tx_tick && tx_cnt_r == '0 && !tx_last_r
                          && !tx_avail;
  wire        tx_load   = tx_tick && tx_cnt_r == '0 && tx_avail;
  wire [6:0]  ifg_ticks = i_mii_mode ? `LF_IFG_MII : `LF_IFG_SER;
  assign tx_done_w = tx_state_r == TX_SEND && !col_hit && tx_end;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tx_state_r     <= TX_IDLE;
      tx_rd_r        <= '0;
      tx_fs_r        <= '0;
      tx_sh_r        <= '0;
      tx_cnt_r       <= '0;
      tx_last_r      <= 1'b0;
      tx_whole_r     <= 1'b0;
      tx_gap_r       <= '0;
      o_txd          <= '0;
      o_tx_en        <= 1'b0;
      o_tx_done      <= 1'b0;
      o_tx_collision <= 1'b0;
      o_tx_underrun  <= 1'b0;
    end else begin
      o_tx_done      <= 1'b0;
      o_tx_collision <= 1'b0;
      o_tx_underrun  <= 1'b0;
      case (tx_state_r)
        // Wait for threshold or a whole frame, then first unit
        TX_IDLE: begin
          if (tx_tick && tx_start && tx_avail) begin
            o_txd      <= unit_of(tx_head.data, i_mii_mode);
            tx_sh_r    <= rest_of(tx_head.data, i_mii_mode);
            tx_cnt_r   <= units_per_byte(i_mii_mode) - 4'h1;
            tx_last_r  <= tx_head.last;
            tx_rd_r    <= tx_rd_r + 1'b1;
            o_tx_en    <= 1'b1;
            tx_state_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (col_hit) begin
            // Collision in half duplex: rewind for a retry
            o_tx_en        <= 1'b0;
            tx_rd_r        <= tx_fs_r;
            tx_cnt_r       <= '0;
            tx_last_r      <= 1'b0;
            o_tx_collision <= 1'b1;
            tx_state_r     <= TX_GAP;
          end else if (tx_end) begin
            // Frame out whole: release its bytes
            o_tx_en    <= 1'b0;
            tx_fs_r    <= tx_rd_r;
            tx_last_r  <= 1'b0;
            tx_whole_r <= 1'b0;
            o_tx_done  <= 1'b1;
            tx_state_r <= TX_GAP;
          end else if (tx_starve) begin
            // Host fell behind: cut frame, resend whole later
            o_tx_en       <= 1'b0;
            tx_rd_r       <= tx_fs_r;
            tx_whole_r    <= 1'b1;
            o_tx_underrun <= 1'b1;
            tx_state_r    <= TX_GAP;
          end else if (tx_load) begin
            o_txd     <= unit_of(tx_head.data, i_mii_mode);
            tx_sh_r   <= rest_of(tx_head.data, i_mii_mode);
            tx_cnt_r  <= units_per_byte(i_mii_mode) - 4'h1;
            tx_last_r <= tx_head.last;
            tx_rd_r   <= tx_rd_r + 1'b1;
          end else if (tx_tick) begin
            o_txd    <= unit_of(tx_sh_r, i_mii_mode);
            tx_sh_r  <= rest_of(tx_sh_r, i_mii_mode);
            tx_cnt_r <= tx_cnt_r - 4'h1;
          end
        end
        // Hold the line idle for the inter_frame_gap
        TX_GAP: begin
          if (tx_tick) begin
            if (tx_gap_r == ifg_ticks - 7'h01) begin
              tx_gap_r   <= '0;
              tx_state_r <= TX_IDLE;
            end else begin
              tx_gap_r <= tx_gap_r + 7'h01;
            end
          end
        end
        default: begin
          o_tx_en    <= 1'b0;
          tx_state_r <= TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receive assembler and receive FIFO write side
  // ------------------------------------------------------------
  fifo_word_s   rx_mem_r [RX_DEPTH];  // Receive storage
  logic [RAW:0] rx_wr_r;              // Link write pointer
  logic [RAW:0] rx_fs_r;              // Start of frame = commit
  logic [RAW:0] rx_rd_r;              // Host read pointer
  logic [7:0]   rx_asm_r;             // Byte under assembly
  logic [3:0]   rx_ucnt_r;            // Units gathered
  logic [6:0]   rx_len_r;             // Bytes, saturates at min
  logic         rx_in_r;              // Frame in progress
  logic         rx_ovf_r;             // Frame overflowed FIFO

  // Data-valid in MII, carrier sense on the serial link
  wire       rx_lvl   = i_mii_mode ? dv_s : crs_s;
  wire [7:0] rx_asm_n = i_mii_mode ? {rxd_s, rx_asm_r[7:4]}
                                   : {rxd_s[0], rx_asm_r[7:1]};
  wire       rx_byte  = rx_ucnt_r == units_per_byte(i_mii_mode) - 4'h1;
  wire       rx_room  = (rx_wr_r - rx_rd_r) < (RAW+1)'(RX_DEPTH);
  wire       rx_short = i_runt_drop && rx_len_r < `LF_MIN_FRAME;
  wire       rx_drop  = rx_ovf_r || rx_short || rx_len_r == '0;

  // Bytes stay invisible to the host until the frame commits, so
  // a dropped frame just rewinds the write pointer.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rx_wr_r       <= '0;
      rx_fs_r       <= '0;
      rx_asm_r      <= '0;
      rx_ucnt_r     <= '0;
      rx_len_r      <= '0;
      rx_in_r       <= 1'b0;
      rx_ovf_r      <= 1'b0;
      o_rx_frame    <= 1'b0;
      o_rx_runt     <= 1'b0;
      o_rx_overflow <= 1'b0;
    end else begin
      o_rx_frame    <= 1'b0;
      o_rx_runt     <= 1'b0;
      o_rx_overflow <= 1'b0;
      if (rx_tick && rx_lvl) begin
        rx_in_r   <= 1'b1;
        rx_asm_r  <= rx_asm_n;
        rx_ucnt_r <= rx_byte ? 4'h0 : rx_ucnt_r + 4'h1;
        if (rx_byte) begin
          if (rx_room && !rx_ovf_r) begin
            rx_mem_r[rx_wr_r[RAW-1:0]] <= '{last: 1'b0, data: rx_asm_n};
            rx_wr_r <= rx_wr_r + 1'b1;
          end else begin
            rx_ovf_r <= 1'b1;
          end
          if (rx_len_r != `LF_MIN_FRAME) begin
            rx_len_r <= rx_len_r + 7'h01;
          end
        end
      end else if (rx_tick && rx_in_r) begin
        // Frame over: commit it or throw it away
        rx_in_r   <= 1'b0;
        rx_ucnt_r <= '0;
        rx_len_r  <= '0;
        rx_ovf_r  <= 1'b0;
        if (rx_drop) begin
          rx_wr_r       <= rx_fs_r;
          o_rx_runt     <= rx_short && !rx_ovf_r;
          o_rx_overflow <= rx_ovf_r;
        end else begin
          rx_mem_r[rx_wr_r[RAW-1:0] - 1'b1].last <= 1'b1;
          rx_fs_r    <= rx_wr_r;
          o_rx_frame <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Receive FIFO read side and two-entry output buffer
  // ------------------------------------------------------------
  fifo_word_s rx_b1_r;    // Second buffer entry
  logic [1:0] rx_bcnt_r;  // Entries held
  logic [1:0] rx_bcnt_nxt;

  wire rx_take = o_rx_valid & i_rx_ready;
  wire rx_pop  = rx_rd_r != rx_fs_r &&
                 (rx_bcnt_r != 2'h2 || rx_take);
  wire fifo_word_s rx_tail = rx_mem_r[rx_rd_r[RAW-1:0]];

  assign rx_bcnt_nxt = rx_bcnt_r + {1'b0, rx_pop} - {1'b0, rx_take};

  // The host may stall freely; the FIFO backs up behind it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rx_rd_r    <= '0;
      rx_bcnt_r  <= '0;
      rx_b1_r    <= '0;
      o_rx_word  <= '0;
      o_rx_valid <= 1'b0;
    end else begin
      rx_bcnt_r  <= rx_bcnt_nxt;
      o_rx_valid <= rx_bcnt_nxt != 2'h0;
      if (rx_pop) begin
        rx_rd_r <= rx_rd_r + 1'b1;
      end
      if (rx_take && rx_bcnt_r == 2'h2) begin
        o_rx_word <= rx_b1_r;
        if (rx_pop) begin
          rx_b1_r <= rx_tail;
        end
      end else if (rx_pop && (rx_bcnt_r == 2'h0 || rx_take)) begin
        o_rx_word <= rx_tail;
      end else if (rx_pop) begin
        rx_b1_r <= rx_tail;
      end
    end
  end

  // Both paths above share nothing, so full duplex needs no
  // arbitration; collision only aborts in half duplex.

endmodule : lan_frame_fifo

`default_nettype wire

// >>> hw/lan_fifo_consts.svh
/*
  Constants of the frame FIFO subsystem: default depths, the minimum
  legal frame length and the inter-frame gap in link clock ticks.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef LAN_FIFO_CONSTS_SVH
`define LAN_FIFO_CONSTS_SVH

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define LF_TX_DEPTH     32'h0000_0800
`define LF_RX_DEPTH     32'h0000_0800
`define LF_MIN_FRAME    7'h40

// ------------------------------------------------------------
// Timing in link clock ticks (96 bit times)
// ------------------------------------------------------------
`define LF_IFG_MII      7'h18
`define LF_IFG_SER      7'h60
`define LF_UNITS_MII    4'h2
`define LF_UNITS_SER    4'h8

`endif

// >>> hw/lan_fifo_pkg.sv
/*
  Types of the frame FIFO subsystem: the FIFO word carrier and the
  transmit sequencer states.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package lan_fifo_pkg;

  // ------------------------------------------------------------
  // One FIFO entry: a byte and its end-of-frame mark
  // ------------------------------------------------------------
  typedef struct packed {
    logic       last;   // Final byte of a frame
    logic [7:0] data;   // Frame byte
  } fifo_word_s;

  // ------------------------------------------------------------
  // Transmit sequencer, one-hot
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_GAP  = 3'b100
  } tx_state_e;

endpackage : lan_fifo_pkg

`default_nettype wire

// >>> test/lan_frame_fifo_sva.sv
/*
  Port checker for lan_frame_fifo: link unit timing, collision reaction
  and host receive hold. Assumes one clock domain, the core clock.
*/
`default_nettype none

module lan_frame_fifo_chk
  import lan_fifo_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_mii_mode,
  input wire logic       i_full_duplex,
  input wire logic       i_col,
  input wire logic       i_rx_ready,
  input wire logic [3:0] o_txd,
  input wire logic       o_tx_en,
  input wire logic       o_tx_done,
  input wire logic       o_tx_collision,
  input wire logic       o_tx_underrun,
  input wire fifo_word_s o_rx_word,
  input wire logic       o_rx_valid,
  input wire logic       o_rx_frame
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Assertions on the core clock
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  done_idle_a: assert property (o_tx_done |-> !o_tx_en)
    else $error("tx done while still enabled");
  serial_bit_a: assert property (
    o_tx_en && !i_mii_mode |-> o_txd[3:1] == 3'h0)
    else $error("serial mode drives upper data lines");
  // A unit lasts a link period; a collision may cut it short
  unit_hold_a: assert property (
    o_tx_en && $changed(o_txd) |=> ($stable(o_txd) || !o_tx_en) [*3])
    else $error("tx unit shorter than a link tick");
  col_stop_a: assert property (
    o_tx_en && i_col && !i_full_duplex |-> ##[1:5] !o_tx_en)
    else $error("tx enable kept through a collision");
  fd_col_a: assert property (
    i_full_duplex [*4] |-> !o_tx_collision)
    else $error("collision reported in full duplex");
  rx_hold_a: assert property (
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_word))
    else $error("rx word dropped while host stalls");
  commit_word_a: assert property (o_rx_frame |-> ##[1:3] o_rx_valid)
    else $error("committed frame not offered to host");
  underrun_end_a: assert property (o_tx_underrun |-> !o_tx_en)
    else $error("frame not ended on underrun");

endmodule : lan_frame_fifo_chk

bind lan_frame_fifo lan_frame_fifo_chk lan_frame_fifo_chk_i (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_mii_mode(i_mii_mode),
  .i_full_duplex(i_full_duplex), .i_col(i_col), .i_rx_ready(i_rx_ready),
  .o_txd(o_txd), .o_tx_en(o_tx_en), .o_tx_done(o_tx_done),
  .o_tx_collision(o_tx_collision), .o_tx_underrun(o_tx_underrun),
  .o_rx_word(o_rx_word), .o_rx_valid(o_rx_valid), .o_rx_frame(o_rx_frame));

`default_nettype wire

// >>> test/phy_model.sv
/*
  Link partner: makes both link clocks, records sent bytes and idle
  gaps, raises collisions and sends receive frames in nibbles or bits.
  Assumes low nibble first and bit 0 first.
*/
`default_nettype none

module phy_model (
  input  wire logic       i_mii,
  input  wire logic [3:0] i_txd,
  input  wire logic       i_tx_en,
  output var  logic       o_tx_clk,
  output var  logic       o_rx_clk,
  output var  logic [3:0] o_rxd,
  output var  logic       o_rx_dv,
  output var  logic       o_col
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] got_q[$]; // Bytes of the latest frame
  logic [7:0] sh_r;     // Byte being assembled
  int         nu;       // Units held in sh_r
  int         gap;      // Idle ticks so far
  int         last_gap; // Idle ticks before the latest frame
  logic       in_f;     // Inside a frame
  logic       busy;     // A receive frame owns the data lines

  initial begin
    {o_tx_clk, o_rx_clk, o_rx_dv, o_col, in_f, busy} = 6'h00;
    o_rxd = 4'h0;
    nu = 0;
    gap = 0;
  end

  // Free-running clocks, receive offset so phases are unrelated
  always #100 o_tx_clk = ~o_tx_clk;
  initial begin
    #37;
    forever #100 o_rx_clk = ~o_rx_clk;
  end

  // Idle data lines change every tick so stale values never match;
  // a running frame owns the lines, so only one process drives them
  always @(negedge o_rx_clk) if (!busy) o_rxd <= ~o_rxd;

  // A unit is launched after a tick and sampled at the next tick
  always @(posedge o_tx_clk) begin
    if (i_tx_en) begin
      if (!in_f) begin
        last_gap = gap;
        got_q.delete();
        nu = 0;
      end
      in_f = 1'b1;
      gap = 0;
      sh_r = i_mii ? {i_txd, sh_r[7:4]} : {i_txd[0], sh_r[7:1]};
      nu++;
      if (nu == (i_mii ? 2 : 8)) begin
        got_q.push_back(sh_r);
        nu = 0;
      end
    end else begin
      in_f = 1'b0;
      gap++;
    end
  end

  // Collision held for three ticks, two ticks in
  task automatic collide();
    repeat (2) @(posedge o_tx_clk);
    o_col = 1'b1;
    repeat (3) @(posedge o_tx_clk);
    o_col = 1'b0;
  endtask : collide

  // Frame of n bytes from base upward, changed on falling edges;
  // low nibble first in MII, bit 0 first on the serial link
  task automatic send_rx(input int n, input logic [7:0] base);
    logic [7:0] b;
    int         u;
    u = i_mii ? 2 : 8;
    busy = 1'b1;
    for (int k = 0; k < u * n; k++) begin
      b = base + 8'(k / u);
      @(negedge o_rx_clk);
      o_rx_dv <= 1'b1;
      o_rxd <= i_mii ? b[4 * (k % 2) +: 4] : {3'h0, b[k % 8]};
    end
    @(negedge o_rx_clk);
    o_rx_dv <= 1'b0;
    busy = 1'b0;
  endtask : send_rx

endmodule : phy_model

`default_nettype wire

// >>> test/test_lan_frame_fifo_subsystem.sv
/*
  Testbench for lan_frame_fifo: host streams on one side, phy_model on
  the link side. Assumes depths of 16 and 5 MHz link clocks.
*/
`default_nettype none

module test_lan_frame_fifo_subsystem
  import lan_fifo_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DEPTH = 16; // Small depth so full is reached quickly
  logic i_core_clk, i_sys_rst, i_mii_mode, i_full_duplex, i_runt_drop;
  logic [$clog2(DEPTH):0] i_tx_threshold;
  fifo_word_s i_tx_word, o_rx_word;
  logic i_tx_valid, o_tx_ready, o_rx_valid, i_rx_ready, tx_clk, rx_clk;
  logic [3:0] o_txd, rxd;
  logic o_tx_en, col, rx_dv, o_tx_done, o_tx_collision, o_tx_underrun;
  logic o_rx_frame, o_rx_runt, o_rx_overflow;
  int n_errors, samples_checked;

  lan_frame_fifo #(.TX_DEPTH(DEPTH), .RX_DEPTH(DEPTH)) lan_frame_fifo_i (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_mii_mode(i_mii_mode), .i_full_duplex(i_full_duplex),
    .i_runt_drop(i_runt_drop), .i_tx_threshold(i_tx_threshold),
    .i_tx_word(i_tx_word), .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready), .o_rx_word(o_rx_word),
    .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready), .i_tx_clk(tx_clk),
    .o_txd(o_txd), .o_tx_en(o_tx_en), .i_col(col), .i_rx_clk(rx_clk),
    .i_rxd(rxd), .i_rx_dv(rx_dv), .i_crs(rx_dv), .o_tx_done(o_tx_done),
    .o_tx_collision(o_tx_collision), .o_tx_underrun(o_tx_underrun),
    .o_rx_frame(o_rx_frame), .o_rx_runt(o_rx_runt),
    .o_rx_overflow(o_rx_overflow));

  phy_model phy_model_i (.i_mii(i_mii_mode), .i_txd(o_txd),
    .i_tx_en(o_tx_en), .o_tx_clk(tx_clk), .o_rx_clk(rx_clk),
    .o_rxd(rxd), .o_rx_dv(rx_dv), .o_col(col));

  always #12.5 i_core_clk = ~i_core_clk;

  // ------------------------------------------------------------
  // Shared tasks; all drives land 1 ns after a rising edge
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : tick

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  function automatic logic pick(input int s);
    case (s)
      0: return o_tx_en;
      1: return o_tx_collision;
      2: return o_tx_underrun;
      3: return o_tx_done;
      4: return o_rx_runt;
      5: return o_rx_frame;
      6: return o_rx_valid;
      8: return o_rx_overflow;
      default: return o_tx_ready;
    endcase
  endfunction : pick

  // Bounded wait; a pulse is seen just after the edge that raises it
  task automatic wait_hi(input int s, input int lim);
    int t;
    t = 0;
    while (pick(s) !== 1'b1 && t < lim) begin
      tick(1);
      t++;
    end
    if (t >= lim) begin
      n_errors++;
      $display("BAD %0t wait %h %h", $time, s, lim);
      tally_and_finish();
    end
  endtask : wait_hi

  // Bytes base.. offered in turn; each held until taken
  task automatic push(input int n, input logic [7:0] base, input logic fin);
    for (int k = 0; k < n; k++) begin
      i_tx_word = '{last: fin && k == n - 1, data: base + 8'(k)};
      i_tx_valid = 1'b1;
      wait_hi(7, 2000);
      tick(1);
    end
    i_tx_valid = 1'b0;
    tick(1);
  endtask : push

  task automatic read_rx(input int n, input logic [7:0] base);
    for (int k = 0; k < n; k++) begin
      wait_hi(6, 200);
      check(32'(o_rx_word), {23'h00_0000, k == n - 1, base + 8'(k)});
      i_rx_ready = 1'b1;
      tick(1);
      i_rx_ready = 1'b0;
      tick(1);
    end
  endtask : read_rx

  task automatic check_tx(input int n, input logic [7:0] base);
    check(32'(phy_model_i.got_q.size()), 32'(n));
    for (int k = 0; k < n && k < phy_model_i.got_q.size(); k++)
      check(32'(phy_model_i.got_q[k]), 32'(base + 8'(k)));
  endtask : check_tx

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_queue_serial();
    push(5, 8'h10, 1'b1);
    push(3, 8'h20, 1'b1);
    wait_hi(3, 3000);
    check_tx(5, 8'h10);
    tick(1);
    wait_hi(3, 3000);
    check_tx(3, 8'h20);
    check(32'(phy_model_i.last_gap inside {[24:26]}), 32'h1);
    i_mii_mode = 1'b0;
    push(2, 8'hC3, 1'b1);
    wait_hi(3, 3000);
    check_tx(2, 8'hC3);
    phy_model_i.send_rx(2, 8'h5A);
    wait_hi(5, 100);
    read_rx(2, 8'h5A);
    i_mii_mode = 1'b1;
    tick(1000);
  endtask : s_queue_serial

  task automatic s_thresh_underrun();
    i_tx_threshold = 5'h08;
    push(7, 8'h30, 1'b0);
    tick(100);
    check(32'(o_tx_en), 32'h0);
    push(1, 8'h37, 1'b0);
    wait_hi(0, 400);
    push(2, 8'h38, 1'b1);
    wait_hi(3, 3000);
    check_tx(10, 8'h30);
    i_tx_threshold = 5'h02;
    push(2, 8'h40, 1'b0);
    wait_hi(2, 1000);
    push(2, 8'h42, 1'b1);
    wait_hi(3, 3000);
    check_tx(4, 8'h40);
  endtask : s_thresh_underrun

  task automatic s_collide_fill();
    i_tx_threshold = 5'h04;
    push(6, 8'h50, 1'b1);
    wait_hi(0, 400);
    fork
      phy_model_i.collide();
      wait_hi(1, 400);
    join
    wait_hi(3, 3000);
    check_tx(6, 8'h50);
    i_tx_threshold = 5'h1F;
    tick(300);
    push(15, 8'h90, 1'b1);
    tick(1);
    check(32'(o_tx_ready), 32'h0);
    wait_hi(3, 3000);
    check_tx(15, 8'h90);
  endtask : s_collide_fill

  task automatic s_duplex_runt();
    i_full_duplex = 1'b1;
    i_tx_threshold = 5'h04;
    tick(300);
    push(6, 8'h60, 1'b1);
    fork
      phy_model_i.collide();
      phy_model_i.send_rx(4, 8'h70);
    join
    wait_hi(5, 100);
    tick(50);
    read_rx(4, 8'h70);
    tick(20);
    check(32'(o_rx_valid), 32'h0);
    check_tx(6, 8'h60);
    i_full_duplex = 1'b0;
    i_runt_drop = 1'b1;
    phy_model_i.send_rx(4, 8'h80);
    wait_hi(4, 100);
    tick(20);
    check(32'(o_rx_valid), 32'h0);
    phy_model_i.send_rx(17, 8'hA0);
    wait_hi(8, 100);
    tick(20);
    check(32'(o_rx_valid), 32'h0);
  endtask : s_duplex_runt

  initial begin
    {i_core_clk, i_sys_rst, i_mii_mode, i_full_duplex} = 4'h6;
    {i_runt_drop, i_tx_valid, i_rx_ready} = 3'h0;
    i_tx_word = '0;
    i_tx_threshold = 5'h04;
    n_errors = 0;
    samples_checked = 0;
    tick(6);
    i_sys_rst = 1'b0;
    tick(4);
    s_queue_serial();
    s_thresh_underrun();
    s_collide_fill();
    s_duplex_runt();
    tally_and_finish();
  end

endmodule : test_lan_frame_fifo_subsystem

`default_nettype wire
